// file: asfp_pkg.sv
// Shared constants and types for the serial frame and power-mode control block
package asfp_pkg;

    // ----------------------------------------------------------------
    // Frame layout, counted in serial-clock falling edges
    // ----------------------------------------------------------------
    localparam int unsigned     CODE_W        = 10;     // Result width
    localparam int unsigned     CNT_W         = 5;      // Edge counter width
    localparam logic [4:0]      EDGE_GUARD    = 5'h02;  // Below this a rise keeps the mode
    localparam logic [4:0]      EDGE_COMMIT   = 5'h0a;  // From this a rise keeps normal mode
    localparam logic [4:0]      EDGE_WORD     = 5'h10;  // Word complete, output floats
    localparam logic [4:0]      EDGE_MSB      = 5'h03;  // Count at which the MSB is driven
    localparam logic [4:0]      EDGE_LSB      = 5'h0c;  // Count at which the LSB is driven
    localparam int unsigned     FRAME_CYCLES  = 20;     // Serial clocks per frame at full rate

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic            CS_IDLE       = 1'b1;   // Select line rests high
    localparam logic [2:0]      FLAGS_RST     = 3'h0;   // Edge flags cleared

    // ----------------------------------------------------------------
    // Power states of the converter
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_SHUTDOWN,    // Analog off, waiting for select low
        ST_WAKE,        // Frame started from shutdown
        ST_NORMAL,      // Analog on, no frame
        ST_FRAME        // Frame started from normal mode, or a wake frame past edge 10
    } asfp_state_t;

endpackage

// file: asfp_sync.sv
// Two-flop synchroniser with asynchronous reset to a constant
`timescale 1ns/1ns
`default_nettype none
module asfp_sync #(
    parameter int unsigned      W       = 1,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    // Destination clock and reset
    input  wire logic           clk,
    input  wire logic           rst_n,
    // Data
    input  wire logic [W-1:0]   d,
    output logic      [W-1:0]   q
);

    logic [W-1:0]               meta_q;

    // ----------------------------------------------------------------
    // Two stages; only the second stage reads the first
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule
`default_nettype wire

// file: asfp_top.sv
// Serial frame, serial output and power-mode control of a 10-bit converter
// Contract
// - Select falling edge enters normal mode and starts a frame, from idle or shutdown.
// - Select rising after edge 2 up to edge 10 aborts, floats output, shuts down.
// - Select rising before the second falling edge leaves the power mode unchanged.
// - Shutdown lasts, analog off, until select is next driven low.
// - Select low past the tenth falling edge ends in normal mode.
// - Select rising between edges 10 and 16 aborts, floats output, stays normal.
// - A full word takes sixteen clocks; output then floats though select stays low.
// - Wake starts at select fall; that conversion is invalid, the next valid.
// - On wake, a rise before the tenth edge falls back into shutdown.
// - Sixteen clocks after wake the converter is fully powered.
// - Continuous normal mode sustains one conversion per twenty serial clocks.
// - Select falling edge drives the output and captures the sample.
// - Output floats after the sixteenth falling edge or at select rise.
// - Three zeros, ten result bits MSB first, three zeros, shifted on falling edges.
`timescale 1ns/1ns
`default_nettype none
module asfp_top #(
    parameter int unsigned              CODE_W = asfp_pkg::CODE_W
) (
    // Core clock and reset
    input  wire logic                   CORE_CLK,
    input  wire logic                   NRST,
    // Serial link pins
    input  wire logic                   SERIAL_CLK,
    input  wire logic                   CONV_SELECT_N,
    output logic                        SERIAL_OUT,
    output logic                        SERIAL_OUT_OE,
    // Converter core
    input  wire logic [CODE_W-1:0]      SAMPLE_CODE,
    output logic                        SAMPLE_HOLD,
    // Power and conversion status
    output logic                        ANALOG_ON,
    output logic                        FULLY_POWERED,
    output logic                        RESULT_VALID,
    output logic                        CONV_DONE,
    output logic                        CONV_ABORT
);

    // ----------------------------------------------------------------
    // Link domain: edge counter, edge flags and shifter
    // ----------------------------------------------------------------
    logic [asfp_pkg::CNT_W-1:0]         edge_cnt_q;
    logic [asfp_pkg::CNT_W-1:0]         edge_cnt_d;
    logic                               reach_guard_q;
    logic                               reach_commit_q;
    logic                               reach_word_q;
    logic                               sdo_q;
    logic                               sdo_d;
    logic [CODE_W-1:0]                  code_q;
    logic                               link_rst_n;
    logic                               cnt_full;
    logic [asfp_pkg::CNT_W-1:0]         bit_sel;

    // Select high holds all link logic cleared; fall starts counting at zero
    assign link_rst_n = ~CONV_SELECT_N;
    assign cnt_full   = (edge_cnt_q == asfp_pkg::EDGE_WORD);
    assign edge_cnt_d = cnt_full ? edge_cnt_q
                                 : edge_cnt_q + {{(asfp_pkg::CNT_W-1){1'b0}}, 1'b1};
    assign bit_sel    = asfp_pkg::EDGE_LSB - edge_cnt_d;

    // Leading zeros, result MSB first, then trailing zeros
    assign sdo_d = (edge_cnt_d >= asfp_pkg::EDGE_MSB && edge_cnt_d <= asfp_pkg::EDGE_LSB)
                   ? code_q[bit_sel[3:0]] : 1'b0;

    // Falling-edge counter saturating at a full word
    always_ff @(negedge SERIAL_CLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            edge_cnt_q <= '0;
        end else begin
            edge_cnt_q <= edge_cnt_d;
        end
    end

    // Sticky edge flags, each a single level for the core to sample
    always_ff @(negedge SERIAL_CLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            reach_guard_q  <= 1'b0;
            reach_commit_q <= 1'b0;
            reach_word_q   <= 1'b0;
        end else begin
            reach_guard_q  <= reach_guard_q  | (edge_cnt_d >= asfp_pkg::EDGE_GUARD);
            reach_commit_q <= reach_commit_q | (edge_cnt_d >= asfp_pkg::EDGE_COMMIT);
            reach_word_q   <= reach_word_q   | (edge_cnt_d >= asfp_pkg::EDGE_WORD);
        end
    end

    // Sample code held from the first falling edge of the frame
    always_ff @(negedge SERIAL_CLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            code_q <= '0;
        end else if (edge_cnt_q == '0) begin
            code_q <= SAMPLE_CODE;
        end
    end

    // Serial data bit, changed only on falling edges
    always_ff @(negedge SERIAL_CLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sdo_q <= 1'b0;
        end else begin
            sdo_q <= sdo_d;
        end
    end

    // ----------------------------------------------------------------
    // Output pin: driven from select fall until word end or select rise
    // ----------------------------------------------------------------
    // The enable must react to select without a clock edge
    assign SERIAL_OUT_OE = ~CONV_SELECT_N & ~reach_word_q;
    assign SERIAL_OUT    = sdo_q;

    // ----------------------------------------------------------------
    // Core domain: reset release and crossings
    // ----------------------------------------------------------------
    logic                               rst_n;
    logic                               sel_n_s;
    logic [2:0]                         flags_s;

    // Reset asserts at once and releases through two flops
    asfp_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
        .clk   (CORE_CLK),
        .rst_n (NRST),
        .d     (1'b1),
        .q     (rst_n)
    );

    // Select level into the core clock
    asfp_sync #(.W(1), .RST_VAL(asfp_pkg::CS_IDLE)) u_sel_sync (
        .clk   (CORE_CLK),
        .rst_n (rst_n),
        .d     (CONV_SELECT_N),
        .q     (sel_n_s)
    );

    // Edge flags are monotonic levels within a frame, safe to sync bitwise
    asfp_sync #(.W(3), .RST_VAL(asfp_pkg::FLAGS_RST)) u_flag_sync (
        .clk   (CORE_CLK),
        .rst_n (rst_n),
        .d     ({reach_word_q, reach_commit_q, reach_guard_q}),
        .q     (flags_s)
    );

    // ----------------------------------------------------------------
    // Core domain: edge detection and flag history
    // ----------------------------------------------------------------
    logic                               sel_n_q;
    logic [2:0]                         flags_q1;
    logic [2:0]                         flags_q2;
    logic                               sel_fall;
    logic                               sel_rise;
    logic                               got_guard;
    logic                               got_commit;
    logic                               got_word;

    // Flags clear with the select rise; judge on copies one and two cycles old
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            sel_n_q  <= asfp_pkg::CS_IDLE;
            flags_q1 <= asfp_pkg::FLAGS_RST;
            flags_q2 <= asfp_pkg::FLAGS_RST;
        end else begin
            sel_n_q  <= sel_n_s;
            flags_q1 <= flags_s;
            flags_q2 <= flags_q1;
        end
    end

    assign sel_fall   = sel_n_q & ~sel_n_s;
    assign sel_rise   = ~sel_n_q & sel_n_s;
    assign got_guard  = flags_q2[0] | flags_q1[0];
    assign got_commit = flags_q2[1] | flags_q1[1];
    assign got_word   = flags_q2[2] | flags_q1[2];

    // ----------------------------------------------------------------
    // Core domain: power state machine
    // ----------------------------------------------------------------
    asfp_pkg::asfp_state_t              state_q;
    asfp_pkg::asfp_state_t              state_d;
    logic                               in_frame;

    assign in_frame = (state_q == asfp_pkg::ST_WAKE) || (state_q == asfp_pkg::ST_FRAME);

    // Next state from select edges and the edge count reached
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            asfp_pkg::ST_SHUTDOWN: begin
                if (sel_fall) begin
                    state_d = asfp_pkg::ST_WAKE;
                end
            end
            asfp_pkg::ST_NORMAL: begin
                if (sel_fall) begin
                    state_d = asfp_pkg::ST_FRAME;
                end
            end
            asfp_pkg::ST_WAKE: begin
                if (sel_rise) begin
                    // Early rise on wake returns to shutdown
                    state_d = got_commit ? asfp_pkg::ST_NORMAL
                                         : asfp_pkg::ST_SHUTDOWN;
                end else if (got_commit) begin
                    state_d = asfp_pkg::ST_FRAME;
                end
            end
            asfp_pkg::ST_FRAME: begin
                if (sel_rise) begin
                    state_d = (got_guard && !got_commit) ? asfp_pkg::ST_SHUTDOWN
                                                          : asfp_pkg::ST_NORMAL;
                end
            end
        endcase
    end

    // Mode unknown at supply start; parked in shutdown until a frame
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= asfp_pkg::ST_SHUTDOWN;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // Core domain: power-up tracking and status outputs
    // ----------------------------------------------------------------
    logic                               powered_q;
    logic                               powered_d;
    logic                               frame_valid_q;
    logic                               word_seen_q;
    logic                               word_end;

    // Powered after a full word since wake; lost on the way to shutdown
    // The status flag takes this next value, so it never outlives the analog supply
    assign word_end  = in_frame & got_word;
    assign powered_d = (state_d == asfp_pkg::ST_SHUTDOWN) ? 1'b0
                     : word_end                           ? 1'b1
                                                          : powered_q;

    // Power-up history register
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            powered_q <= 1'b0;
        end else begin
            powered_q <= powered_d;
        end
    end

    // A frame is valid only if the converter was powered at its start
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            frame_valid_q <= 1'b0;
        end else if (sel_fall) begin
            frame_valid_q <= powered_q && (state_q == asfp_pkg::ST_NORMAL);
        end
    end

    // Word completion seen once per frame
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            word_seen_q <= 1'b0;
        end else if (sel_fall) begin
            word_seen_q <= 1'b0;
        end else if (in_frame && got_word) begin
            word_seen_q <= 1'b1;
        end
    end

    // Registered status toward the converter core and system
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ANALOG_ON     <= 1'b0;
            FULLY_POWERED <= 1'b0;
            SAMPLE_HOLD   <= 1'b0;
            RESULT_VALID  <= 1'b0;
            CONV_DONE     <= 1'b0;
            CONV_ABORT    <= 1'b0;
        end else begin
            ANALOG_ON     <= (state_d != asfp_pkg::ST_SHUTDOWN);
            FULLY_POWERED <= powered_d;
            SAMPLE_HOLD   <= ~sel_n_s & ~(in_frame & got_word);
            CONV_DONE     <= in_frame & got_word & ~word_seen_q;
            CONV_ABORT    <= in_frame & sel_rise & ~got_word & got_guard;
            if (in_frame && got_word && !word_seen_q) begin
                RESULT_VALID <= frame_valid_q;
            end else if (sel_fall) begin
                RESULT_VALID <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// file: asfp_monitor.sv
// Assertion checker bound to the converter frame control block
`timescale 1ns/1ns
`default_nettype none
module asfp_monitor (
    // Core clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // Link pins
    input wire logic CONV_SELECT_N,
    input wire logic SERIAL_OUT,
    input wire logic SERIAL_OUT_OE,
    // Status
    input wire logic SAMPLE_HOLD,
    input wire logic ANALOG_ON,
    input wire logic FULLY_POWERED,
    input wire logic RESULT_VALID,
    input wire logic CONV_DONE,
    input wire logic CONV_ABORT
);
    // ------------------------------------------------------------
    // Checks on the core clock
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);
    // Data pin only driven inside a frame, low while select is high, open at select fall
    oe_select_a: assert property (SERIAL_OUT_OE |-> !CONV_SELECT_N)
        else $error("Data driven with select high");
    out_quiet_a: assert property (CONV_SELECT_N |-> !SERIAL_OUT)
        else $error("Data not low with select high");
    oe_open_a: assert property ($fell(CONV_SELECT_N) |-> SERIAL_OUT_OE)
        else $error("Data not driven after select fall");
    // Pulses last one cycle and never coincide
    done_pulse_a: assert property (CONV_DONE |=> !CONV_DONE)
        else $error("Done pulse too long");
    abort_pulse_a: assert property (CONV_ABORT |=> !CONV_ABORT)
        else $error("Abort pulse too long");
    abort_cause_a: assert property (CONV_ABORT |-> CONV_SELECT_N && !CONV_DONE)
        else $error("Abort without select rise");
    // Power flags keep their order
    power_order_a: assert property (FULLY_POWERED |-> ANALOG_ON)
        else $error("Powered flag while analog off");
    shut_hold_a: assert property (!ANALOG_ON && CONV_SELECT_N |=> !ANALOG_ON)
        else $error("Left shutdown without select low");
    valid_done_a: assert property ($rose(RESULT_VALID) |-> CONV_DONE && FULLY_POWERED)
        else $error("Result valid without powered word");
    wake_a: assert property ($rose(SAMPLE_HOLD) |-> ##[0:3] ANALOG_ON)
        else $error("Frame did not enter normal mode");
endmodule
bind asfp_top asfp_monitor u_mon (
    .CORE_CLK(CORE_CLK), .NRST(NRST), .CONV_SELECT_N(CONV_SELECT_N),
    .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_OE(SERIAL_OUT_OE), .SAMPLE_HOLD(SAMPLE_HOLD),
    .ANALOG_ON(ANALOG_ON), .FULLY_POWERED(FULLY_POWERED), .RESULT_VALID(RESULT_VALID),
    .CONV_DONE(CONV_DONE), .CONV_ABORT(CONV_ABORT)
);
`default_nettype wire

// file: asfp_host_model.sv
// Host controller model: frames conversions and reads the serial word
`timescale 1ns/1ns
`default_nettype none
module asfp_host_model #(
    parameter int HOLD_NS  = 60,    // Select low after the last clock edge
    parameter int QUIET_NS = 60     // Quiet gap before the next frame
) (
    // Frame request
    input  wire logic       go,
    input  wire logic [4:0] n_edges,
    output int              frames,
    // Link pins
    output logic            sclk,
    output logic            cs_n,
    input  wire logic       serial_out,
    input  wire logic       oe,
    // Captured bits and drive enables
    output logic [15:0]     word,
    output logic [20:0]     oe_seen
);
    // Link clock stands low between frames, 6 ns period inside them
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        frames = 0;
        forever begin
            @(posedge go);
            word = '0;
            oe_seen = '0;
            #2 cs_n = 1'b0;
            // Offset of 4 ns from select fall to the first link rising edge
            #4;
            for (int i = 0; i < n_edges; i++) begin
                sclk = 1'b1;
                // Sample on the rise; a released pin reads inverted
                if (i < 16) word[15-i] = oe ? serial_out : ~serial_out;
                oe_seen[i] = oe;
                #3 sclk = 1'b0;
                #3;
            end
            oe_seen[n_edges] = oe;
            #HOLD_NS cs_n = 1'b1;
            #QUIET_NS frames++;
        end
    end
endmodule
`default_nettype wire

// file: asfp_top_tb.sv
// Self-checking bench for the converter frame and power-mode block
`timescale 1ns/1ns
`default_nettype none
module asfp_top_tb;
    // ------------------------------------------------------------
    // Signals, rows and counters
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] n;      // Falling edges before select rises
        logic [9:0] code;   // Converter code for the frame
        logic [3:0] exp;    // Analog on, abort, done, fully powered
        logic [1:0] vl;     // Valid flag expected, 2 skips it
    } asfp_row_t;
    logic        core_clk, nrst, sclk, cs_n, sout, sout_oe, go;
    logic        hold, analog_on, powered, valid, done, abort;
    logic [9:0]  code;
    logic [4:0]  n_edges;
    logic [15:0] word;
    logic [20:0] oe_seen;
    int          frames, err_count, tests_run, n_done, n_abort;
    asfp_row_t   rows [11] = '{
        '{5'h10, 10'h2a5, 4'hb, 2'h0}, '{5'h10, 10'h15a, 4'hb, 2'h1},
        '{5'h01, 10'h3ff, 4'h9, 2'h0}, '{5'h0c, 10'h001, 4'hd, 2'h0},
        '{5'h02, 10'h200, 4'h4, 2'h0}, '{5'h01, 10'h155, 4'h0, 2'h0},
        '{5'h09, 10'h0aa, 4'h4, 2'h0}, '{5'h0a, 10'h0f0, 4'hc, 2'h0},
        '{5'h14, 10'h30c, 4'hb, 2'h2}, '{5'h10, 10'h0c3, 4'hb, 2'h1},
        '{5'h0e, 10'h111, 4'hd, 2'h0}};

    // Core clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Design and host model
    asfp_top uut (
        .CORE_CLK(core_clk), .NRST(nrst), .SERIAL_CLK(sclk), .CONV_SELECT_N(cs_n),
        .SERIAL_OUT(sout), .SERIAL_OUT_OE(sout_oe), .SAMPLE_CODE(code),
        .SAMPLE_HOLD(hold), .ANALOG_ON(analog_on), .FULLY_POWERED(powered),
        .RESULT_VALID(valid), .CONV_DONE(done), .CONV_ABORT(abort));
    asfp_host_model host (
        .go(go), .n_edges(n_edges), .frames(frames), .sclk(sclk), .cs_n(cs_n),
        .serial_out(sout), .oe(sout_oe), .word(word), .oe_seen(oe_seen));

    // Count core pulses during each frame
    always @(posedge core_clk) begin
        if (done === 1'b1) n_done++;
        if (abort === 1'b1) n_abort++;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One frame from a row, then its expectations
    task automatic run_row(input int i);
        int t;
        int f;
        @(negedge core_clk);
        code = rows[i].code;
        n_edges = rows[i].n;
        n_done = 0;
        n_abort = 0;
        f = frames;
        go = 1'b1;
        t = 0;
        while (frames == f && t < 2000) begin
            @(negedge core_clk);
            t++;
        end
        go = 1'b0;
        check(t < 2000, "frame timeout");
        if (t >= 2000) tally_and_finish();
        check({analog_on, powered, hold} === {rows[i].exp[3], rows[i].exp[0], 1'b0}, "mode");
        check(n_abort == rows[i].exp[2] && n_done == rows[i].exp[1], "pulses");
        if (rows[i].vl != 2'h2) check(valid === rows[i].vl[0], "valid flag");
        if (rows[i].n >= 5'h0f) check(word[15:1] === {3'h0, rows[i].code, 2'h0}, "word");
        for (int k = 0; k <= rows[i].n; k++) check(oe_seen[k] === (k < 16), "enable");
        $display("Row %0d done at %0t", i, $time);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        go = 1'b0;
        code = '0;
        n_edges = '0;
        err_count = 0;
        tests_run = 0;
        repeat (20) @(negedge core_clk);
        check({sout_oe, analog_on, powered, valid, done, abort, hold} === 7'h0, "reset");
        $display("Reset test done");
        nrst = 1'b1;
        repeat (5) @(negedge core_clk);
        foreach (rows[i]) run_row(i);
        // Reset in mid-run: shutdown, then a dummy word and a valid one
        nrst = 1'b0;
        repeat (20) @(negedge core_clk);
        check({analog_on, powered, valid} === 3'h0, "second reset");
        nrst = 1'b1;
        repeat (5) @(negedge core_clk);
        run_row(0);
        run_row(1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
